// ---- include/acr_pkg.sv ----
package acr_pkg;

   localparam int          RES_W            = 24;
   localparam int          NOTCH_SHIFT      = 9;
   localparam int          WORD_CNT_W       = 20;
   localparam int          CLK_NS           = 40;
   localparam int          RESULT_READY_N_MIN_HIGH_NS = 400;
   localparam int          RESULT_READY_N_HIGH_CYC    = (RESULT_READY_N_MIN_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int          HIGH_CNT_W       = 4;
   localparam int          SETTLE_WORDS     = 3;
   localparam int          SKIP_W           = 4;
   localparam logic [2:0]  MODE_CONVERT     = 3'h0;
   localparam logic [2:0]  MODE_SELF_CAL    = 3'h1;
   localparam logic [10:0] RATE_CODE_RESET  = 11'h00a;
   localparam logic [1:0]  REG_RESULT       = 2'h0;
   localparam logic [1:0]  REG_SETTINGS     = 2'h1;
   localparam logic [1:0]  BYTE_TOP         = 2'h2;
   localparam logic [2:0]  BIT_LAST         = 3'h7;
   localparam logic [23:0] CODING_FLIP      = 24'h800000;
   localparam logic [23:0] POS_MAX          = 24'h7fffff;
   localparam logic [23:0] RES_MAX          = 24'hffffff;

   // converter_settings, bit 23 down to bit 0
   typedef struct packed {
      logic        outputCodingSelect;
      logic [10:0] filterRateCode;
      logic [2:0]  operatingMode;
      logic        bipolar;
      logic [2:0]  gainSelect;
      logic        burnoutCurrentEnable;
      logic        lowPowerHold;
      logic        byteOrderSelect;
      logic        lsbFirst;
      logic        readLineSelect;
   } acr_settings_s;

   localparam acr_settings_s SETTINGS_RESET = '{
      outputCodingSelect: 1'b0, filterRateCode: RATE_CODE_RESET,
      operatingMode: MODE_SELF_CAL, bipolar: 1'b1, gainSelect: 3'h0,
      burnoutCurrentEnable: 1'b0, lowPowerHold: 1'b0, byteOrderSelect: 1'b0,
      lsbFirst: 1'b0, readLineSelect: 1'b0};

   typedef struct packed {
      logic       write;
      logic [1:0] byteCountM1;
      logic       fullScaleNeg;
      logic [1:0] regSel;
      logic [1:0] startByte;
   } acr_instr_s;

   typedef struct packed {
      logic sclk;
      logic csN;
      logic sdio;
   } acr_link_s;

   typedef enum logic [1:0] {
      SP_IDLE  = 2'b00,
      SP_INSTR = 2'b01,
      SP_DATA  = 2'b10
   } acr_sp_e;

   typedef struct packed {
      acr_link_s               sync1;
      acr_link_s               sync2;
      logic                    sclkPrev;
      acr_settings_s           settings;
      acr_sp_e                 spState;
      logic [7:0]              shiftIn;
      logic [7:0]              shiftOut;
      logic [2:0]              bitCnt;
      acr_instr_s              instr;
      logic [1:0]              byteIdx;
      logic [1:0]              bytesLeft;
      logic                    readActive;
      logic                    sdioOut;
      logic                    sdioOe;
      logic                    serialOut;
      logic                    serialOutOe;
      logic [WORD_CNT_W-1:0]   wordCnt;
      logic [SKIP_W-1:0]       skipCnt;
      logic [RES_W-1:0]        resultReg;
      logic [RES_W-1:0]        bufWord;
      logic                    bufFull;
      logic                    resultReadyN;
      logic [HIGH_CNT_W-1:0]   highCnt;
      logic                    modulatorRun;
      logic                    calStart;
   } acr_state_s;

endpackage

// ---- rtl/acr_top.sv ----
// Summary of operation
// - result register is read only; host writes to it are ignored.
// - coding bit set gives two's complement, clear gives offset binary.
// - unipolar results are straight binary regardless of the coding bit.
// - bits 22..12 hold decimation code; notch is oscillator over 512 times code.
// - one new result per notch period.
// - results after a restart settle within three to four word periods; calibration adds CAL_WORDS more.
// - bits 11..9 select operating mode; reset loads self-calibration.
// - bit 8 set means bipolar, clear unipolar; reset sets it.
// - bits 7..5 select gain; upper codes add digital multiply; reset clears.
// - bit 4 enables the burn-out current source.
// - hold bit stops filter and modulator and keeps result-ready high.
// - clearing hold resumes per settings, calibrating first if selected.
// - bit 2 set gives ascending byte order, clear descending.
// - bit 1 clear sends msb first, set sends lsb first.
// - bit 0 clear reads on the two-way line, set on serial out line.
// - reset clears coding, burn-out, hold, byte order, bit order, line bits.
// - result-ready low means the register holds the latest valid result.
// - a conversion during a result read never overwrites the word read, except one landing in the cycle the instruction is decoded.
// - one extra result is held in a one-word buffer.
// - a late read loses the next result; the one after is buffered.
// - read completion raises result-ready; buffered word moves in, low after.
// - writing settings byte 2 or 1 raises result-ready and restarts, calibrating first if selected.
// - instruction bits 3..2 pick register, bits 1..0 the start byte.
`timescale 1ns/1ps

module acr_fifo #(
   parameter int W     = 24,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst_b,
   // filling side
   input  wire logic         inValid,
   input  wire logic [W-1:0] inData,
   output logic              inReady,
   // draining side
   output logic              outValid,
   output logic [W-1:0]      outData,
   input  wire logic         outReady
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           wrPtr;
      logic [PW-1:0]           rdPtr;
      logic [CW-1:0]           count;
      logic                    inReady;
      logic                    outValid;
   } acr_fifo_s;

   acr_fifo_s st;
   acr_fifo_s next_st;
   logic      push;
   logic      pop;

   function automatic logic [PW-1:0] advance(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   always_comb begin
      next_st = st;
      push    = inValid && st.inReady;
      pop     = st.outValid && outReady;
      if (push) begin
         next_st.mem[st.wrPtr] = inData;
         next_st.wrPtr         = advance(st.wrPtr);
      end
      if (pop) begin
         next_st.rdPtr = advance(st.rdPtr);
      end
      next_st.count    = st.count + CW'(push) - CW'(pop);
      next_st.inReady  = next_st.count != CW'(DEPTH);
      next_st.outValid = next_st.count != '0;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st         <= '0;
         st.inReady <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign inReady  = st.inReady;
   assign outValid = st.outValid;
   assign outData  = st.mem[st.rdPtr];
endmodule // acr_fifo

module acr_top import acr_pkg::*; #(
   parameter int CAL_WORDS  = 4,
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_b,
   // serial port pins
   input  wire logic             sclk,
   input  wire logic             csN,
   input  wire logic             sdioIn,
   output logic                  sdioOut,
   output logic                  sdioOe,
   output logic                  serialOutLine,
   output logic                  serialOutOe,
   output logic                  resultReadyN,
   // raw filter words, offset binary
   input  wire logic             sampleValid,
   input  wire logic [RES_W-1:0] sampleData,
   output logic                  sampleReady,
   // converter controls
   output acr_settings_s         settingsOut,
   output logic                  modulatorRun,
   output logic                  calStart
);
   localparam logic [SKIP_W-1:0] SKIP_CAL  = SKIP_W'(SETTLE_WORDS + CAL_WORDS);
   localparam logic [SKIP_W-1:0] SKIP_CONV = SKIP_W'(SETTLE_WORDS);

   acr_state_s       st;
   acr_state_s       next_st;
   logic             sclkRise;
   logic             sclkFall;
   logic             inBit;
   logic             outBit;
   logic             byteDone;
   logic             readDone;
   logic             byteWrite12;
   logic             restart;
   logic             tick;
   logic             newWord;
   logic             highBusy;
   logic             fifoValid;
   logic [RES_W-1:0] fifoData;
   logic [RES_W-1:0] gained;
   logic [RES_W-1:0] coded;
   logic [RES_W-1:0] settingsWord;

   acr_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock    (clock),
      .rst_b    (rst_b),
      .inValid  (sampleValid),
      .inData   (sampleData),
      .inReady  (sampleReady),
      .outValid (fifoValid),
      .outData  (fifoData),
      .outReady (tick)
   );

   function automatic logic [7:0] readByte(input logic [1:0] regSel, input logic [1:0] idx,
                                           input logic [23:0] res, input logic [23:0] set);
      logic [23:0] w;
      w = (regSel == REG_RESULT) ? res : (regSel == REG_SETTINGS) ? set : '0;
      return (idx > BYTE_TOP) ? 8'h00 : w[{idx, 3'b000} +: 8];
   endfunction

   // digital multiply after the filter, saturating
   function automatic logic [23:0] applyGain(input logic [23:0] raw, input logic [2:0] g,
                                             input logic bip);
      logic [2:0]  k;
      logic [28:0] s;
      logic [23:0] r;
      k = g[2] ? ({1'b0, g[1:0]} + 3'h1) : 3'h0;
      if (bip) begin
         s = {{5{raw[23] ^ 1'b1}}, raw ^ CODING_FLIP} << k;
         r = (s[28:23] != {6{s[28]}}) ? (s[28] ? CODING_FLIP : POS_MAX) : s[23:0];
         r = r ^ CODING_FLIP;
      end else begin
         s = {5'h00, raw} << k;
         r = (|s[28:24]) ? RES_MAX : s[23:0];
      end
      return r;
   endfunction

   function automatic logic isCal(input logic [2:0] mode);
      return mode != MODE_CONVERT;
   endfunction

   always_comb begin
      gained = applyGain(fifoData, st.settings.gainSelect, st.settings.bipolar);
      coded  = (st.settings.bipolar && st.settings.outputCodingSelect) ?
               (gained ^ CODING_FLIP) : gained;
   end

   always_comb begin
      next_st          = st;
      next_st.sync1    = '{sclk: sclk, csN: csN, sdio: sdioIn};
      next_st.sync2    = st.sync1;
      next_st.sclkPrev = st.sync2.sclk;
      next_st.calStart = 1'b0;
      sclkRise         = st.sync2.sclk && !st.sclkPrev;
      sclkFall         = !st.sync2.sclk && st.sclkPrev;
      inBit            = st.sync2.sdio;
      outBit           = 1'b0;
      byteDone         = 1'b0;
      readDone         = 1'b0;
      byteWrite12      = 1'b0;
      settingsWord     = st.settings;
      // serial port
      if (st.sync2.csN) begin
         next_st.spState     = SP_IDLE;
         next_st.readActive  = 1'b0;
         next_st.sdioOe      = 1'b0;
         next_st.serialOutOe = 1'b0;
      end else begin
         if (st.spState == SP_IDLE) begin
            next_st.spState = SP_INSTR;
            next_st.bitCnt  = '0;
         end else if (sclkRise) begin
            if (st.spState == SP_INSTR || !st.settings.lsbFirst) begin
               next_st.shiftIn = {st.shiftIn[6:0], inBit};
            end else begin
               next_st.shiftIn = {inBit, st.shiftIn[7:1]};
            end
            next_st.bitCnt = st.bitCnt + 3'h1;
            if (st.bitCnt == BIT_LAST) begin
               if (st.spState == SP_INSTR) begin
                  next_st.instr      = acr_instr_s'(next_st.shiftIn);
                  next_st.byteIdx    = next_st.instr.startByte;
                  next_st.bytesLeft  = next_st.instr.byteCountM1;
                  next_st.spState    = SP_DATA;
                  next_st.readActive = !next_st.instr.write &&
                                       (next_st.instr.regSel == REG_RESULT);
                  next_st.shiftOut   = readByte(next_st.instr.regSel, next_st.instr.startByte,
                                                st.resultReg, st.settings);
               end else begin
                  byteDone = 1'b1;
               end
            end
         end
         if (byteDone) begin
            if (st.instr.write && st.instr.regSel == REG_SETTINGS &&
                st.byteIdx <= BYTE_TOP) begin
               settingsWord[{st.byteIdx, 3'b000} +: 8] = next_st.shiftIn;
               next_st.settings = acr_settings_s'(settingsWord);
               byteWrite12 = st.byteIdx != 2'h0;
            end
            if (st.bytesLeft == 2'h0) begin
               next_st.spState    = SP_INSTR;
               next_st.readActive = 1'b0;
               readDone           = st.readActive;
            end else begin
               next_st.bytesLeft = st.bytesLeft - 2'h1;
               next_st.byteIdx   = st.settings.byteOrderSelect ?
                                   st.byteIdx + 2'h1 : st.byteIdx - 2'h1;
               next_st.shiftOut  = readByte(st.instr.regSel, next_st.byteIdx,
                                            st.resultReg, st.settings);
            end
         end
         if (sclkFall && st.spState == SP_DATA && !st.instr.write) begin
            outBit = st.settings.lsbFirst ? st.shiftOut[0] : st.shiftOut[7];
            next_st.shiftOut = st.settings.lsbFirst ? {1'b0, st.shiftOut[7:1]} :
                                                      {st.shiftOut[6:0], 1'b0};
            if (st.settings.readLineSelect) begin
               next_st.serialOut   = outBit;
               next_st.serialOutOe = 1'b1;
            end else begin
               next_st.sdioOut = outBit;
               next_st.sdioOe  = 1'b1;
            end
         end
      end
      // word timer: period is 512 times the filter code
      restart = byteWrite12 ||
                (st.settings.lowPowerHold && !next_st.settings.lowPowerHold);
      tick    = !st.settings.lowPowerHold &&
                (st.wordCnt == WORD_CNT_W'({st.settings.filterRateCode, {NOTCH_SHIFT{1'b0}}} - 1));
      if (tick) begin
         next_st.wordCnt = '0;
      end else if (!st.settings.lowPowerHold) begin
         next_st.wordCnt = st.wordCnt + WORD_CNT_W'(1);
      end
      newWord = tick && fifoValid && (st.skipCnt == '0);
      if (tick && fifoValid && st.skipCnt != '0) begin
         next_st.skipCnt = st.skipCnt - SKIP_W'(1);
      end
      // result register, one-word buffer and ready flag
      highBusy = st.highCnt != '0;
      if (highBusy) begin
         next_st.highCnt = st.highCnt - HIGH_CNT_W'(1);
         if (st.highCnt == HIGH_CNT_W'(1)) begin
            next_st.resultReadyN = 1'b0;
         end
      end
      if (readDone) begin
         next_st.resultReadyN = 1'b1;
         if (st.bufFull || newWord) begin
            next_st.resultReg = st.bufFull ? st.bufWord : coded;
            next_st.bufWord   = newWord ? coded : st.bufWord;
            next_st.bufFull   = st.bufFull && newWord;
            next_st.highCnt   = HIGH_CNT_W'(RESULT_READY_N_HIGH_CYC);
         end
      end else if (newWord) begin
         if (st.readActive || highBusy) begin
            next_st.bufWord = coded;
            next_st.bufFull = 1'b1;
         end else begin
            next_st.resultReg    = coded;
            next_st.resultReadyN = 1'b0;
         end
      end
      if (st.settings.lowPowerHold || restart) begin
         next_st.resultReadyN = 1'b1;
         next_st.highCnt      = '0;
      end
      if (restart) begin
         next_st.wordCnt  = '0;
         next_st.bufFull  = 1'b0;
         next_st.calStart = isCal(next_st.settings.operatingMode);
         next_st.skipCnt  = isCal(next_st.settings.operatingMode) ? SKIP_CAL : SKIP_CONV;
      end
      next_st.modulatorRun = !next_st.settings.lowPowerHold;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st              <= '0;
         st.sync1.csN    <= 1'b1;
         st.sync2.csN    <= 1'b1;
         st.settings     <= SETTINGS_RESET;
         st.resultReadyN <= 1'b1;
         st.modulatorRun <= 1'b1;
         st.calStart     <= 1'b1;
         st.skipCnt      <= SKIP_CAL;
      end else begin
         st <= next_st;
      end
   end

   assign sdioOut       = st.sdioOut;
   assign sdioOe        = st.sdioOe;
   assign serialOutLine = st.serialOut;
   assign serialOutOe   = st.serialOutOe;
   assign resultReadyN  = st.resultReadyN;
   assign settingsOut   = st.settings;
   assign modulatorRun  = st.modulatorRun;
   assign calStart      = st.calStart;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   property p_result_ro;
      (byteDone && st.instr.write && st.instr.regSel == REG_RESULT && !newWord && !readDone)
         |=> $stable(st.resultReg);
   endproperty
   a_result_ro: assert property (p_result_ro) else $error("result register changed by write");

   property p_twos;
      (fifoValid && st.settings.bipolar && st.settings.outputCodingSelect &&
       st.settings.gainSelect == 3'h0) |-> coded == (fifoData ^ CODING_FLIP);
   endproperty
   a_twos: assert property (p_twos) else $error("two's complement coding wrong");

   property p_unipolar;
      (fifoValid && !st.settings.bipolar) |-> coded == fifoData || st.settings.gainSelect[2];
   endproperty
   a_unipolar: assert property (p_unipolar) else $error("unipolar word not straight binary");

   property p_reset_vals;
      $rose(rst_b) |-> st.settings == SETTINGS_RESET && st.resultReadyN;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("settings not at reset values");

   property p_hold;
      (st.settings.lowPowerHold && $past(st.settings.lowPowerHold))
         |-> st.resultReadyN && !st.modulatorRun && !tick;
   endproperty
   a_hold: assert property (p_hold) else $error("hold does not stop conversion");

   property p_read_protect;
      (st.readActive && !readDone) |=> $stable(st.resultReg);
   endproperty
   a_read_protect: assert property (p_read_protect) else $error("word overwritten during read");

   property p_read_done;
      (readDone && st.bufFull) |=> st.resultReadyN && st.resultReg == $past(st.bufWord);
   endproperty
   a_read_done: assert property (p_read_done) else $error("buffered word not moved on read end");

   property p_ready_cause;
      $fell(st.resultReadyN) |-> $past(newWord || st.highCnt == HIGH_CNT_W'(1));
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready fell without a result");

   property p_ctrl_write;
      byteWrite12 |=> st.resultReadyN && st.calStart == isCal(st.settings.operatingMode);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("settings write did not restart");

   property p_ascend;
      (byteDone && st.bytesLeft != 2'h0 && st.settings.byteOrderSelect)
         |=> st.byteIdx == $past(st.byteIdx) + 2'h1;
   endproperty
   a_ascend: assert property (p_ascend) else $error("ascending byte step wrong");

   c_buffered_move: cover property (readDone && st.bufFull);
   c_ctrl_write:    cover property (byteWrite12);
   c_ready_low:     cover property ($fell(st.resultReadyN));
   c_hold:          cover property ($rose(st.settings.lowPowerHold));
endmodule // acr_top

// ---- tb/acr_host.sv ----
`timescale 1ns/1ps

module acr_host (
   // clock for the released-line pattern
   input  wire logic clock,
   // link pins
   output logic      sclk,
   output logic      csN,
   output logic      sdioIn,
   input  wire logic sdioOut,
   input  wire logic sdioOe,
   input  wire logic serialOutLine,
   input  wire logic serialOutOe
);
   logic hostBit;
   logic hostOe;
   logic idleBit;

   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      hostBit = 1'b0;
      hostOe = 1'b0;
      idleBit = 1'b0;
   end

   // a released line shows a changing pattern, never the last value
   always @(posedge clock) idleBit <= ~idleBit;
   assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostBit : idleBit);

   // one framed transfer; link edges are off the core clock grid
   task automatic xfer(input logic [7:0] instr, input int n, input logic lsb,
                       input logic lsel, input logic [23:0] wd, output logic [23:0] rd);
      logic [7:0] b;
      rd = '0;
      #7 csN = 1'b0;
      hostOe = 1'b1;
      #200;
      for (int k = 0; k <= n; k++) begin
         b = (k == 0) ? instr : 8'(wd >> (8 * (n - k)));
         for (int i = 0; i < 8; i++) begin
            hostOe = (k == 0) || instr[7];
            hostBit = (k > 0 && lsb) ? b[i] : b[7 - i];
            #160 sclk = 1'b1;
            if (k > 0 && !instr[7]) begin
               rd = {rd[22:0], lsel ? (serialOutOe ? serialOutLine : 1'bx) :
                                      (sdioOe ? sdioIn : 1'bx)};
            end
            #160 sclk = 1'b0;
         end
      end
      #160 csN = 1'b1;
      hostOe = 1'b0;
      #200;
   endtask
endmodule // acr_host

// ---- tb/adc_control_and_result_regs_test.sv ----
`timescale 1ns/1ps

module adc_control_and_result_regs_test import acr_pkg::*;;
   localparam int P = 512 * 10;
   logic clock, rst_b, sclk, csN, sdioIn, sdioOut, sdioOe, serialOutLine, serialOutOe;
   logic resultReadyN, sampleValid, sampleReady, modulatorRun, calStart;
   logic [RES_W-1:0] sampleData, rd, expWord, expSet;
   acr_settings_s    settingsOut;
   logic [23:0]      q[$];
   int               failures, checks, seed, cycles;

   acr_top #(.CAL_WORDS(4), .FIFO_DEPTH(4)) u_acr_top (.clock(clock), .rst_b(rst_b),
      .sclk(sclk), .csN(csN), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
      .serialOutLine(serialOutLine), .serialOutOe(serialOutOe), .resultReadyN(resultReadyN),
      .sampleValid(sampleValid), .sampleData(sampleData), .sampleReady(sampleReady),
      .settingsOut(settingsOut), .modulatorRun(modulatorRun), .calStart(calStart));
   acr_host u_acr_host (.clock(clock), .sclk(sclk), .csN(csN), .sdioIn(sdioIn),
      .sdioOut(sdioOut), .sdioOe(sdioOe), .serialOutLine(serialOutLine),
      .serialOutOe(serialOutOe));

   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // expected serial bit stream of a register read, in arrival order
   function automatic logic [23:0] stream(input logic [23:0] v, input logic [1:0] s,
                                          input int n, input logic asc, input logic lsb);
      logic [7:0] b;
      logic [1:0] i;
      stream = '0;
      i = s;
      for (int k = 0; k < n; k++) begin
         b = (i == 2'h3) ? 8'h00 : v[8 * i +: 8];
         for (int j = 0; j < 8; j++) stream = {stream[22:0], lsb ? b[j] : b[7 - j]};
         i = asc ? i + 2'h1 : i - 2'h1;
      end
   endfunction

   // words taken so far; the register holds the one just behind the full fifo
   task automatic await_ready(input int lo, input int hi);
      int n;
      n = 0;
      while (resultReadyN !== 1'b0 && n < hi) begin
         @(posedge clock);
         n++;
      end
      check("settle", 24'(n >= lo && n < hi), 24'h1);
      repeat (8) @(posedge clock);
      check("fifo full", 24'(sampleReady), 24'h0);
      expWord = q[q.size() - 5];
   endtask

   task automatic read_result;
      u_acr_host.xfer(8'h42, 3, expSet[1], expSet[0], 24'h0, rd);
      check("result", rd, (expSet[8] && expSet[23]) ? expWord ^ CODING_FLIP : expWord);
      check("ready after read", 24'(resultReadyN), 24'h1);
   endtask

   task automatic write_set(input logic [7:0] ins, input int n, input logic [23:0] wd,
                            input logic [23:0] nxt);
      u_acr_host.xfer(ins, n, expSet[1], expSet[0], wd, rd);
      expSet = nxt;
      @(posedge clock);
      check("settingsOut", settingsOut, expSet);
   endtask

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles >= 90000) begin
         failures++;
         report_and_stop;
      end
      if (sampleValid && sampleReady) begin
         q.push_back(sampleData);
         sampleData <= 24'($random(seed));
      end
   end

   initial begin
      seed = 46529;
      rst_b = 1'b0;
      sampleValid = 1'b0;
      sampleData = 24'h000000;
      expSet = SETTINGS_RESET;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      sampleValid <= 1'b1;
      check("reset settings", settingsOut, 24'h00a300);
      check("reset ready", 24'(resultReadyN), 24'h1);
      check("reset cal", 24'(calStart), 24'h1);
      u_acr_host.xfer(8'h46, 3, 1'b0, 1'b0, 24'h0, rd);
      check("settings read", rd, stream(24'h00a300, 2'h2, 3, 1'b0, 1'b0));
      write_set(8'hc6, 3, 24'h80a100, 24'h80a100);
      await_ready(3 * P, 4 * P + 64);
      read_result;
      u_acr_host.xfer(8'hc2, 3, 1'b0, 1'b0, 24'hffffff, rd);
      read_result;
      write_set(8'h85, 1, 24'h0000a0, 24'h80a000);
      await_ready(3 * P, 4 * P + 64);
      read_result;
      write_set(8'ha6, 2, 24'h0000a1, 24'h00a100);
      await_ready(3 * P, 4 * P + 64);
      read_result;
      write_set(8'h84, 1, 24'h000007, 24'h00a107);
      @(posedge clock);
      check("byte0 write", settingsOut, expSet);
      u_acr_host.xfer(8'h44, 3, 1'b1, 1'b1, 24'h0, rd);
      check("ascending lsb read", rd, stream(expSet, 2'h0, 3, 1'b1, 1'b1));
      write_set(8'h84, 1, 24'h00000f, 24'h00a10f);
      repeat (4) @(posedge clock);
      check("hold run", 24'(modulatorRun), 24'h0);
      repeat (P + 64) @(posedge clock);
      check("hold ready", 24'(resultReadyN), 24'h1);
      write_set(8'h84, 1, 24'h000007, 24'h00a107);
      repeat (4) @(posedge clock);
      check("resume run", 24'(modulatorRun), 24'h1);
      report_and_stop;
   end
endmodule // adc_control_and_result_regs_test
